// *** core/sbems_regs.v ***
`timescale 1ns/1ps
`include "sbems_defs.vh"

module sbems_regs (
  input wire i_clock,
  input wire i_reset,
  input wire i_link_fund_reset,
  input wire i_global_reset_pin,
  input wire [`SBEMS_ADDR_WIDTH-1:0] i_cfg_addr,
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [3:0] i_cfg_be,
  input wire [31:0] i_cfg_wdata,
  input wire [`SBEMS_CLASS_WIDTH-1:0] i_err_detect,
  input wire i_first_ptr_hold,
  output reg [31:0] o_cfg_rdata,
  output reg o_cfg_rvalid,
  output reg o_cfg_hit,
  output reg [`SBEMS_CLASS_WIDTH-1:0] o_status_set,
  output reg [`SBEMS_CLASS_WIDTH-1:0] o_msg_req,
  output reg [`SBEMS_CLASS_WIDTH-1:0] o_msg_fatal,
  output reg o_hdr_log_load,
  output reg o_first_ptr_load,
  output reg [`SBEMS_PTR_WIDTH-1:0] o_first_ptr,
  output reg [`SBEMS_CLASS_WIDTH-1:0] o_gate_now,
  output reg [`SBEMS_CLASS_WIDTH-1:0] o_level_now
);

  // storage covers bits 13:0 only, the rest of the word reads zero
  localparam [31:0] MASK_WORD = `SBEMS_MASK_RESET;
  localparam [31:0] SEV_WORD = `SBEMS_SEVERITY_RESET;
  localparam [`SBEMS_CLASS_WIDTH-1:0] MASK_INIT =
    MASK_WORD[`SBEMS_CLASS_WIDTH-1:0];
  localparam [`SBEMS_CLASS_WIDTH-1:0] SEV_INIT =
    SEV_WORD[`SBEMS_CLASS_WIDTH-1:0];
  localparam [`SBEMS_CLASS_WIDTH-1:0] WMASK = `SBEMS_WRITABLE;

  function sbems_sel;
    input [`SBEMS_ADDR_WIDTH-1:0] addr;
    input [`SBEMS_ADDR_WIDTH-1:0] offset;
    begin
      // word decode, byte lane bits ignored
      sbems_sel = (addr[`SBEMS_ADDR_WIDTH-1:2] ==
                   offset[`SBEMS_ADDR_WIDTH-1:2]);
    end
  endfunction

  function [`SBEMS_CLASS_WIDTH-1:0] sbems_merge;
    input [`SBEMS_CLASS_WIDTH-1:0] old;
    input [31:0] data;
    input [3:0] be;
    reg [`SBEMS_CLASS_WIDTH-1:0] lanes;
    begin
      lanes = {{6{be[1]}}, {8{be[0]}}} & WMASK;
      sbems_merge = (old & ~lanes) |
                    (data[`SBEMS_CLASS_WIDTH-1:0] & lanes);
    end
  endfunction

  reg [`SBEMS_CLASS_WIDTH-1:0] gate_reg;
  reg [`SBEMS_CLASS_WIDTH-1:0] gate_next;
  reg [`SBEMS_CLASS_WIDTH-1:0] level_reg;
  reg [`SBEMS_CLASS_WIDTH-1:0] level_next;
  reg [31:0] rdata_next;
  reg hit_next;
  wire restore;
  wire sel_gate;
  wire sel_level;
  wire [`SBEMS_CLASS_WIDTH-1:0] report;
  wire [`SBEMS_CLASS_WIDTH-1:0] fatal;
  wire any_report;
  wire [`SBEMS_PTR_WIDTH-1:0] first_pos;
  wire internal_fault_gate;
  wire sys_err_seen_gate;
  wire parity_err_seen_gate;
  wire delayed_expiry_gate;
  wire addr_parity_gate;
  wire attribute_fault_gate;
  wire data_parity_gate;
  wire split_msg_fault_gate;
  wire split_unexpected_gate;
  wire initiator_abort_gate;
  wire responder_abort_gate;
  wire split_initiator_abort_gate;
  wire internal_fault_level;
  wire sys_err_seen_level;
  wire parity_err_seen_level;
  wire delayed_expiry_level;
  wire addr_parity_level;
  wire attribute_fault_level;
  wire data_parity_level;
  wire split_msg_fault_level;
  wire split_unexpected_level;
  wire initiator_abort_level;
  wire responder_abort_level;
  wire split_initiator_abort_level;
  wire [31:0] gate_word;
  wire [31:0] level_word;

  // all three reset sources restore the same defaults
  assign restore = i_reset | i_link_fund_reset | i_global_reset_pin;
  assign sel_gate = sbems_sel(i_cfg_addr, `SBEMS_MASK_OFFSET);
  assign sel_level = sbems_sel(i_cfg_addr, `SBEMS_SEVERITY_OFFSET);

  assign internal_fault_gate = gate_reg[`SBEMS_BIT_INTERNAL];
  assign sys_err_seen_gate = gate_reg[`SBEMS_BIT_SYS_ERR_SEEN];
  assign parity_err_seen_gate = gate_reg[`SBEMS_BIT_PARITY_ERR_SEEN];
  assign delayed_expiry_gate = gate_reg[`SBEMS_BIT_DELAYED_EXPIRY];
  assign addr_parity_gate = gate_reg[`SBEMS_BIT_ADDR_PARITY];
  assign attribute_fault_gate = gate_reg[`SBEMS_BIT_ATTRIBUTE];
  assign data_parity_gate = gate_reg[`SBEMS_BIT_DATA_PARITY];
  assign split_msg_fault_gate = gate_reg[`SBEMS_BIT_SPLIT_MSG];
  assign split_unexpected_gate = gate_reg[`SBEMS_BIT_SPLIT_UNEXP];
  assign initiator_abort_gate = gate_reg[`SBEMS_BIT_INITIATOR_ABORT];
  assign responder_abort_gate = gate_reg[`SBEMS_BIT_RESPONDER_ABORT];
  assign split_initiator_abort_gate = gate_reg[`SBEMS_BIT_SPLIT_INIT_ABORT];
  assign internal_fault_level = level_reg[`SBEMS_BIT_INTERNAL];
  assign sys_err_seen_level = level_reg[`SBEMS_BIT_SYS_ERR_SEEN];
  assign parity_err_seen_level = level_reg[`SBEMS_BIT_PARITY_ERR_SEEN];
  assign delayed_expiry_level = level_reg[`SBEMS_BIT_DELAYED_EXPIRY];
  assign addr_parity_level = level_reg[`SBEMS_BIT_ADDR_PARITY];
  assign attribute_fault_level = level_reg[`SBEMS_BIT_ATTRIBUTE];
  assign data_parity_level = level_reg[`SBEMS_BIT_DATA_PARITY];
  assign split_msg_fault_level = level_reg[`SBEMS_BIT_SPLIT_MSG];
  assign split_unexpected_level = level_reg[`SBEMS_BIT_SPLIT_UNEXP];
  assign initiator_abort_level = level_reg[`SBEMS_BIT_INITIATOR_ABORT];
  assign responder_abort_level = level_reg[`SBEMS_BIT_RESPONDER_ABORT];
  assign split_initiator_abort_level =
    level_reg[`SBEMS_BIT_SPLIT_INIT_ABORT];

  // reserved positions are tied here, not trusted to storage
  assign gate_word = {18'h0, internal_fault_gate, sys_err_seen_gate,
    parity_err_seen_gate, delayed_expiry_gate, addr_parity_gate,
    attribute_fault_gate, data_parity_gate, split_msg_fault_gate,
    split_unexpected_gate, 1'b0, initiator_abort_gate,
    responder_abort_gate, split_initiator_abort_gate, 1'b0};
  assign level_word = {18'h0, internal_fault_level, sys_err_seen_level,
    parity_err_seen_level, delayed_expiry_level, addr_parity_level,
    attribute_fault_level, data_parity_level, split_msg_fault_level,
    split_unexpected_level, 1'b0, initiator_abort_level,
    responder_abort_level, split_initiator_abort_level, 1'b0};

  always @* begin
    gate_next = gate_reg;
    level_next = level_reg;
    if (i_cfg_wr && sel_gate) begin
      gate_next = sbems_merge(gate_reg, i_cfg_wdata, i_cfg_be);
    end
    if (i_cfg_wr && sel_level) begin
      level_next = sbems_merge(level_reg, i_cfg_wdata, i_cfg_be);
    end
  end

  always @* begin
    rdata_next = 32'h00000000;
    hit_next = 1'b0;
    if (sel_gate) begin
      rdata_next = gate_word;
      hit_next = 1'b1;
    end else if (sel_level) begin
      rdata_next = level_word;
      hit_next = 1'b1;
    end
  end

  always @(posedge i_clock) begin
    if (restore) begin
      gate_reg <= MASK_INIT;
      level_reg <= SEV_INIT;
    end else begin
      gate_reg <= gate_next;
      level_reg <= level_next;
    end
  end

  // gate uses the settled register value, so a same-cycle write
  // only affects errors detected on later edges
  sbems_err_gate u_gate (
    .i_detect(i_err_detect),
    .i_gate(gate_reg),
    .i_level(level_reg),
    .o_report(report),
    .o_fatal(fatal),
    .o_any(any_report),
    .o_first(first_pos)
  );

  always @(posedge i_clock) begin
    if (restore) begin
      o_cfg_rdata <= 32'h00000000;
      o_cfg_rvalid <= 1'b0;
      o_cfg_hit <= 1'b0;
      o_status_set <= {`SBEMS_CLASS_WIDTH{1'b0}};
      o_msg_req <= {`SBEMS_CLASS_WIDTH{1'b0}};
      o_msg_fatal <= {`SBEMS_CLASS_WIDTH{1'b0}};
      o_hdr_log_load <= 1'b0;
      o_first_ptr_load <= 1'b0;
      o_first_ptr <= {`SBEMS_PTR_WIDTH{1'b0}};
      o_gate_now <= MASK_INIT;
      o_level_now <= SEV_INIT;
    end else begin
      o_cfg_rvalid <= i_cfg_rd;
      o_cfg_hit <= i_cfg_rd & hit_next;
      o_cfg_rdata <= i_cfg_rd ? rdata_next : 32'h00000000;
      // status block clears on write-one itself; we only set
      o_status_set <= report;
      o_msg_req <= report;
      o_msg_fatal <= fatal;
      o_hdr_log_load <= any_report;
      o_first_ptr_load <= any_report & ~i_first_ptr_hold;
      if (any_report && !i_first_ptr_hold) begin
        o_first_ptr <= first_pos;
      end
      o_gate_now <= gate_next;
      o_level_now <= level_next;
    end
  end
endmodule

// *** core/sbems_defs.vh ***
`ifndef SBEMS_DEFS_VH
`define SBEMS_DEFS_VH

// configuration byte offsets
`define SBEMS_MASK_OFFSET 12'h130
`define SBEMS_SEVERITY_OFFSET 12'h134
`define SBEMS_ADDR_WIDTH 12

// reset values
`define SBEMS_MASK_RESET 32'h000017A8
`define SBEMS_SEVERITY_RESET 32'h00001340

// storage width: bits 13..0, bits above are reserved
`define SBEMS_CLASS_WIDTH 14

// writable bits: 13..5 and 3..1, bits 4 and 0 reserved
`define SBEMS_WRITABLE 14'h3FEE

// classes that steer the bridge: 12, 11, 10, 9, 7, 3, 2
`define SBEMS_ACTIVE 14'h1E8C

// class bit positions
`define SBEMS_BIT_INTERNAL 13
`define SBEMS_BIT_SYS_ERR_SEEN 12
`define SBEMS_BIT_PARITY_ERR_SEEN 11
`define SBEMS_BIT_DELAYED_EXPIRY 10
`define SBEMS_BIT_ADDR_PARITY 9
`define SBEMS_BIT_ATTRIBUTE 8
`define SBEMS_BIT_DATA_PARITY 7
`define SBEMS_BIT_SPLIT_MSG 6
`define SBEMS_BIT_SPLIT_UNEXP 5
`define SBEMS_BIT_INITIATOR_ABORT 3
`define SBEMS_BIT_RESPONDER_ABORT 2
`define SBEMS_BIT_SPLIT_INIT_ABORT 1

// pointer width
`define SBEMS_PTR_WIDTH 5

`endif

// *** core/sbems_err_gate.v ***
`timescale 1ns/1ps
`include "sbems_defs.vh"

module sbems_err_gate (
  input wire [`SBEMS_CLASS_WIDTH-1:0] i_detect,
  input wire [`SBEMS_CLASS_WIDTH-1:0] i_gate,
  input wire [`SBEMS_CLASS_WIDTH-1:0] i_level,
  output wire [`SBEMS_CLASS_WIDTH-1:0] o_report,
  output wire [`SBEMS_CLASS_WIDTH-1:0] o_fatal,
  output wire o_any,
  output wire [`SBEMS_PTR_WIDTH-1:0] o_first
);

  // highest reporting position wins a same-cycle tie
  function [`SBEMS_PTR_WIDTH-1:0] sbems_pick;
    input [`SBEMS_CLASS_WIDTH-1:0] vec;
    integer k;
    begin
      sbems_pick = {`SBEMS_PTR_WIDTH{1'b0}};
      for (k = 0; k < `SBEMS_CLASS_WIDTH; k = k + 1) begin
        if (vec[k]) begin
          sbems_pick = k[`SBEMS_PTR_WIDTH-1:0];
        end
      end
    end
  endfunction

  localparam [`SBEMS_CLASS_WIDTH-1:0] ACTIVE = `SBEMS_ACTIVE;

  genvar g;
  generate
    for (g = 0; g < `SBEMS_CLASS_WIDTH; g = g + 1) begin : gen_class
      // extended-bus classes never report, whatever their gate
      assign o_report[g] = i_detect[g] & ~i_gate[g] &
                           ACTIVE[g];
      assign o_fatal[g] = o_report[g] & i_level[g];
    end
  endgenerate

  assign o_any = |o_report;
  assign o_first = sbems_pick(o_report);
endmodule

// *** bench/sbems_chk_asserts.sv ***
`timescale 1ns/1ps
module sbems_chk (
  input wire i_clock,
  input wire i_reset,
  input wire i_link_fund_reset,
  input wire i_global_reset_pin,
  input wire i_cfg_rd,
  input wire [13:0] i_err_detect,
  input wire i_first_ptr_hold,
  input wire [31:0] o_cfg_rdata,
  input wire o_cfg_rvalid,
  input wire [13:0] o_status_set,
  input wire [13:0] o_msg_req,
  input wire [13:0] o_msg_fatal,
  input wire o_hdr_log_load,
  input wire o_first_ptr_load,
  input wire [13:0] o_gate_now,
  input wire [13:0] o_level_now
);
  wire rst = i_reset | i_link_fund_reset | i_global_reset_pin;
  // gate as held before the edge, only steering classes
  wire [13:0] rep = i_err_detect & ~o_gate_now & 14'h1E8C;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (rst);
  property p_st; !$past(rst) |-> o_status_set == $past(rep); endproperty
  a_st: assert property (p_st) else $error("status set wrong");
  property p_mq; !$past(rst) |-> o_msg_req == $past(rep); endproperty
  a_mq: assert property (p_mq) else $error("message request wrong");
  property p_fa; !$past(rst) |->
    (o_msg_fatal & o_msg_req) == (o_msg_req & $past(o_level_now)); endproperty
  a_fa: assert property (p_fa) else $error("severity wrong");
  property p_hl; !$past(rst) |-> o_hdr_log_load == |$past(rep); endproperty
  a_hl: assert property (p_hl) else $error("header load wrong");
  property p_pl; !$past(rst) |->
    o_first_ptr_load == (|$past(rep) && !$past(i_first_ptr_hold)); endproperty
  a_pl: assert property (p_pl) else $error("pointer load wrong");
  property p_df; $past(rst) |->
    o_gate_now == 14'h17A8 && o_level_now == 14'h1340; endproperty
  a_df: assert property (p_df) else $error("defaults wrong");
  property p_rs; ((o_gate_now | o_level_now) & 14'h0011) == 14'h0
    && o_cfg_rdata[31:14] == 18'h0; endproperty
  a_rs: assert property (p_rs) else $error("reserved bit set");
  property p_rv; !$past(rst) |-> o_cfg_rvalid == $past(i_cfg_rd); endproperty
  a_rv: assert property (p_rv) else $error("read valid wrong");
endmodule
bind sbems_regs sbems_chk u_chk (
  .i_clock(i_clock),
  .i_reset(i_reset),
  .i_link_fund_reset(i_link_fund_reset),
  .i_global_reset_pin(i_global_reset_pin),
  .i_cfg_rd(i_cfg_rd),
  .i_err_detect(i_err_detect),
  .i_first_ptr_hold(i_first_ptr_hold),
  .o_cfg_rdata(o_cfg_rdata),
  .o_cfg_rvalid(o_cfg_rvalid),
  .o_status_set(o_status_set),
  .o_msg_req(o_msg_req),
  .o_msg_fatal(o_msg_fatal),
  .o_hdr_log_load(o_hdr_log_load),
  .o_first_ptr_load(o_first_ptr_load),
  .o_gate_now(o_gate_now),
  .o_level_now(o_level_now)
);

// *** bench/sbems_root_model.sv ***
`timescale 1ns/1ps
module sbems_root_model (
  input wire i_clock,
  input wire [13:0] i_msg_req,
  input wire [13:0] i_msg_fatal,
  input wire [13:0] i_status_set,
  input wire [13:0] i_status_clear,
  output integer o_n_fatal,
  output integer o_n_nonfatal,
  output logic [13:0] o_status
);
  initial o_n_fatal = 0;
  initial o_n_nonfatal = 0;
  initial o_status = 14'h0;
  // one message per class, each with its own level
  always @(posedge i_clock) begin
    o_n_fatal <= o_n_fatal + $countones(i_msg_req & i_msg_fatal);
    o_n_nonfatal <= o_n_nonfatal + $countones(i_msg_req & ~i_msg_fatal);
    // software clears by writing one; a same-edge set still wins
    o_status <= (o_status & ~i_status_clear) | i_status_set;
  end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, lrst = 0, global_reset_pin = 0, rd = 0, wr = 0, hold = 0;
  logic [11:0] addr = 12'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [13:0] det = 14'h0;
  logic [13:0] clr = 14'h0;
  wire [13:0] stat;
  wire [31:0] rdata;
  wire rvalid, hit, hdr, pld;
  wire [13:0] sset, mreq, mfat, gnow, lnow;
  wire [4:0] ptr;
  integer n_fail = 0, checked = 0, cyc = 0, nf, nn;
  always #2.5 clk = ~clk;
  sbems_regs u_dut (.i_clock(clk), .i_reset(rst), .i_link_fund_reset(lrst),
    .i_global_reset_pin(global_reset_pin), .i_cfg_addr(addr), .i_cfg_wr(wr),
    .i_cfg_rd(rd), .i_cfg_be(be), .i_cfg_wdata(wd), .i_err_detect(det),
    .i_first_ptr_hold(hold), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
    .o_cfg_hit(hit), .o_status_set(sset), .o_msg_req(mreq),
    .o_msg_fatal(mfat), .o_hdr_log_load(hdr), .o_first_ptr_load(pld),
    .o_first_ptr(ptr), .o_gate_now(gnow), .o_level_now(lnow));
  sbems_root_model u_root (.i_clock(clk), .i_msg_req(mreq),
    .i_msg_fatal(mfat), .i_status_set(sset), .i_status_clear(clr),
    .o_n_fatal(nf), .o_n_nonfatal(nn), .o_status(stat));
  task chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk) #1;
    {wr, addr, be, wd} = {1'b1, a, b, d};
    @(posedge clk) #1;
    wr = 0;
  endtask
  task rd_reg(input logic [11:0] a, input logic [31:0] e, input logic h);
    @(posedge clk) #1;
    {rd, addr} = {1'b1, a};
    @(posedge clk) #1;
    rd = 0;
    chk({hit, rvalid, rdata}, {h, 1'b1, e});
  endtask
  task fire(input logic [13:0] v, r, f, input logic l, input logic [4:0] p);
    @(posedge clk) #1;
    det = v;
    @(posedge clk) #1;
    det = 0;
    chk({sset, mreq}, {r, r});
    chk(mfat & mreq, f);
    chk({hdr, pld}, {|r, l});
    if (l) chk(ptr, p);
  endtask
  task t_dflt;
    rd_reg(12'h130, 32'h17A8, 1);
    rd_reg(12'h134, 32'h1340, 1);
    rd_reg(12'h138, 32'h0, 0);
    $display("defaults done");
  endtask
  task t_rw;
    wr_reg(12'h130, 4'hF, 32'hFFFFFFFF);
    rd_reg(12'h130, 32'h3FEE, 1);
    wr_reg(12'h134, 4'hF, 32'hFFFFFFFF);
    rd_reg(12'h134, 32'h3FEE, 1);
    // low lane only, bits 13:8 stay masked
    wr_reg(12'h130, 4'h1, 32'h0);
    rd_reg(12'h130, 32'h3F00, 1);
    chk({gnow, lnow}, {14'h3F00, 14'h3FEE});
    $display("access done");
  endtask
  task t_err;
    fire(14'h3FFF, 14'h008C, 14'h008C, 1, 5'd7);
    hold = 1;
    wr_reg(12'h134, 4'hF, 32'h0);
    fire(14'h0004, 14'h0004, 14'h0, 0, 5'd0);
    hold = 0;
    fire(14'h0400, 14'h0, 14'h0, 0, 5'd0);
    // write and detection on one edge: the old gate still applies
    fork
      wr_reg(12'h130, 4'hF, 32'h0);
      fire(14'h0400, 14'h0, 14'h0, 0, 5'd0);
    join
    fire(14'h0400, 14'h0400, 14'h0, 1, 5'd10);
    @(posedge clk) #1;
    clr = 14'h0404;
    @(posedge clk) #1;
    clr = 14'h0;
    chk(stat, 14'h0088);
    chk(nf, 3);
    chk(nn, 2);
    $display("errors done");
  endtask
  task t_rst;
    for (int k = 0; k < 2; k++) begin
      wr_reg(12'h134, 4'hF, 32'h0);
      @(posedge clk) #1;
      {lrst, global_reset_pin} = (k == 0) ? 2'b10 : 2'b01;
      @(posedge clk) #1;
      {lrst, global_reset_pin} = 2'b00;
      rd_reg(12'h134, 32'h1340, 1);
    end
    $display("resets done");
  endtask
  task tally_and_finish;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 0;
    t_dflt;
    t_rw;
    t_err;
    t_rst;
    tally_and_finish;
  end
endmodule
